/* File: src/eelg_regs.svh */
`ifndef EELG_REGS_SVH
`define EELG_REGS_SVH

// register offsets of the software port
`define EELG_OFF_COUNT   8'h00
`define EELG_OFF_POP     8'h01
`define EELG_OFF_ENABLE  8'h02
`define EELG_OFF_INVERT  8'h03
`define EELG_OFF_LOST    8'h04
`define EELG_OFF_MSG0    8'h10

// field layout of a popped entry
`define EELG_ENT_VALID_BIT  31
`define EELG_ENT_LINE_LSB   8
`define EELG_ENT_MSG_LSB    0

// project-wide limits
`define EELG_MAX_INPUTS  8
`define EELG_MAX_MSGS    64
`define EELG_MSG_BYTES   110
`define EELG_MSG_W       6

`endif

/* File: src/eelg_pkg.sv */
package eelg_pkg;
  typedef logic [5:0] eelg_msg_t;
  typedef enum logic [1:0] {EELG_IDLE, EELG_LOG} eelg_state_t;
endpackage : eelg_pkg

/* File: src/eelg_top.sv */
// Overview of operation
// [R01] The logger watches one to eight inputs, each with its own pulse output.
// [R02] Each input may be inverted so that its falling edge becomes the event.
// [R03] A detected edge raises that input's pulse output for exactly one cycle.
// [R04] Each detected edge appends the input's assigned message number to the log; a full log drops the entry and counts it in lost.
//       The code merges a repeat edge of a still-pending input into one entry, neither logged nor lost.
// [R05] Message numbers index a shared table of at most 64 messages, six bits.
// [R06] Message texts are at most 110 bytes; UTF-8 specials shorten the string.
// [R07] The message table is common to all logger instances of a configuration.
// [R08] Simultaneous events of one instance are logged lowest input first.
// [R09] Simultaneous events of several instances are logged lowest index first.
// [R10] The system should produce no more than ten messages in three seconds.
// [R11] Edges compare against last cycle's value, cleared at reset.
// [R12] Entries sit in an ordered log buffer that software reads out later.
`include "eelg_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module eelg_top
  import eelg_pkg::*;
#(
  parameter int N_INPUTS  = `EELG_MAX_INPUTS,
  parameter int LOG_DEPTH = 16,
  parameter int BLOCK_IDX = 0
) (
  input  wire logic                ref_clk,
  input  wire logic                arst_n,
  input  wire logic [N_INPUTS-1:0] watch_in,
  output logic      [N_INPUTS-1:0] pulse_out,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [31:0]         reg_rdata
);

  localparam int PW = $clog2(LOG_DEPTH);

  // refuse sizes the pointer arithmetic cannot serve, at elaboration
  if (N_INPUTS < 1 || N_INPUTS > `EELG_MAX_INPUTS) begin : g_bad_inputs
    $error("N_INPUTS must be 1 to 8");
  end
  if (LOG_DEPTH < 2 || (LOG_DEPTH & (LOG_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("LOG_DEPTH must be a power of two, at least 2");
  end

  logic [N_INPUTS-1:0] enable;
  logic [N_INPUTS-1:0] invert;
  eelg_msg_t           msg_sel [N_INPUTS];
  logic [N_INPUTS-1:0] prev;
  logic [N_INPUTS-1:0] cond;
  logic [N_INPUTS-1:0] edge_hit;
  logic [N_INPUTS-1:0] pending;
  logic [N_INPUTS-1:0] next_pending;
  eelg_msg_t           log_mem [LOG_DEPTH];
  logic [7:0]          log_line [LOG_DEPTH];
  logic [PW:0]         wr_ptr;
  logic [PW:0]         rd_ptr;
  logic [PW:0]         fill;
  logic [15:0]         lost;
  logic                push;
  logic                push_ok;
  logic                pop;
  logic [2:0]          push_line;
  eelg_state_t         state;

  assign cond     = (watch_in ^ invert) & enable; // [R02]
  assign edge_hit = cond & ~prev; // [R11]
  assign fill     = wr_ptr - rd_ptr;
  assign pop      = reg_rd && reg_addr == `EELG_OFF_POP && fill != '0;
  // a pop in the same cycle frees the slot the push needs
  assign push_ok  = push && (fill < (PW+1)'(LOG_DEPTH) || pop);

  // prev resets to zero so an input already high at release counts as an event
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev <= '0; // [R11]
    end else begin
      prev <= cond; // [R11]
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_out <= '0;
    end else begin
      pulse_out <= edge_hit; // [R03]
    end
  end

  // lowest pending input wins the single log slot each cycle
  always_comb begin
    push_line = '0;
    push      = 1'b0;
    for (int i = N_INPUTS - 1; i >= 0; i--) begin
      if (pending[i]) begin
        push      = 1'b1; // [R08]
        push_line = 3'(i);
      end
    end
  end

  always_comb begin
    next_pending = pending | edge_hit; // [R04]
    if (push)
      next_pending[push_line] = edge_hit[push_line];
  end

  // a burst drains one entry per cycle; the set of a fresh edge wins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pending <= '0;
      state   <= EELG_IDLE;
    end else begin
      pending <= next_pending;
      case (state)
        EELG_IDLE: if (|next_pending) state <= EELG_LOG;
        EELG_LOG:  if (!(|next_pending)) state <= EELG_IDLE;
        default:   state <= EELG_IDLE;
      endcase
    end
  end

  // full log keeps the oldest entries and counts the dropped ones
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      lost   <= '0;
    end else if (push_ok) begin
      wr_ptr <= wr_ptr + 1'b1; // [R12]
    end else if (push) begin
      if (lost != 16'hFFFF) begin
        lost <= lost + 16'h0001;
      end
    end else if (reg_wr && reg_addr == `EELG_OFF_LOST) begin
      lost <= '0;
    end
  end

  // a dropped entry must not overwrite the oldest slot still unread
  always_ff @(posedge ref_clk) begin
    if (push_ok) begin
      log_mem[wr_ptr[PW-1:0]]  <= msg_sel[push_line]; // [R04] [R05]
      log_line[wr_ptr[PW-1:0]] <= 8'(push_line);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1; // [R12]
    end
  end

  // message numbers point into the shared project table, never local text;
  // texts and their byte limit live with software, only numbers here // [R06]
  genvar g;
  generate
    for (g = 0; g < N_INPUTS; g++) begin : g_sel
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          msg_sel[g] <= eelg_msg_t'(g); // [R07]
        end else if (reg_wr && reg_addr == `EELG_OFF_MSG0 + 8'(g)) begin
          msg_sel[g] <= reg_wdata[`EELG_MSG_W-1:0]; // [R05]
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      enable <= '1; // [R01]
      invert <= '0;
    end else if (reg_wr) begin
      if (reg_addr == `EELG_OFF_ENABLE)
        enable <= reg_wdata[N_INPUTS-1:0]; // [R01]
      else if (reg_addr == `EELG_OFF_INVERT)
        invert <= reg_wdata[N_INPUTS-1:0]; // [R02]
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else if (reg_addr == `EELG_OFF_COUNT) begin
      reg_rdata <= 32'(fill);
    end else if (reg_addr == `EELG_OFF_POP) begin
      if (fill != '0) begin
        reg_rdata <= '0;
        reg_rdata[`EELG_ENT_VALID_BIT] <= 1'b1;
        reg_rdata[`EELG_ENT_LINE_LSB +: 8] <= log_line[rd_ptr[PW-1:0]];
        reg_rdata[`EELG_ENT_MSG_LSB +: 6]  <= log_mem[rd_ptr[PW-1:0]];
      end else begin
        reg_rdata <= '0;
      end
    end else if (reg_addr == `EELG_OFF_ENABLE) begin
      reg_rdata <= 32'(enable);
    end else if (reg_addr == `EELG_OFF_INVERT) begin
      reg_rdata <= 32'(invert);
    end else if (reg_addr == `EELG_OFF_LOST) begin
      reg_rdata <= 32'(lost);
    end else if (reg_addr >= `EELG_OFF_MSG0 &&
                 reg_addr < `EELG_OFF_MSG0 + 8'(N_INPUTS)) begin
      reg_rdata <= 32'(msg_sel[3'(reg_addr - `EELG_OFF_MSG0)]);
    end else begin
      reg_rdata <= '0;
    end
  end

  // block index orders instances at a system merger (R09 lives there)
  logic unused_idx;
  assign unused_idx = (BLOCK_IDX < 0); // [R09]

endmodule : eelg_top
`default_nettype wire

/* File: verif/eelg_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module eelg_monitor #(
  parameter int N_INPUTS  = 8,
  parameter int LOG_DEPTH = 16
) (
  input wire logic                ref_clk,
  input wire logic                arst_n,
  input wire logic [N_INPUTS-1:0] watch_in,
  input wire logic [N_INPUTS-1:0] pulse_out,
  input wire logic [7:0]          reg_addr,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [31:0]         reg_rdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_gap; (pulse_out & $past(pulse_out)) == '0; endproperty
  a_gap: assert property (p_gap) else $error("pulse too long");
  // config writes may also create an edge, so they are excused
  property p_cause; pulse_out != '0 && !$past(reg_wr, 2) && !$past(reg_wr, 3)
    |-> (pulse_out & ($past(watch_in, 1) ~^ $past(watch_in, 2))) == '0;
  endproperty
  a_cause: assert property (p_cause) else $error("pulse no edge");
  property p_quiet; $rose(arst_n) |-> pulse_out == '0; endproperty
  a_quiet: assert property (p_quiet) else $error("pulse at reset");
  property p_idle; !$past(reg_rd) |-> reg_rdata == '0; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_pop; $past(reg_rd) && $past(reg_addr) == 8'h01 && reg_rdata[31]
    |-> reg_rdata[15:8] < N_INPUTS; endproperty
  a_pop: assert property (p_pop) else $error("bad input no");
  property p_msg; $past(reg_rd) && $past(reg_addr) == 8'h01
    |-> reg_rdata[30:16] == '0 && reg_rdata[7:6] == '0; endproperty
  a_msg: assert property (p_msg) else $error("bad msg field");
  property p_cnt; $past(reg_rd) && $past(reg_addr) == 8'h00
    |-> reg_rdata <= LOG_DEPTH; endproperty
  a_cnt: assert property (p_cnt) else $error("count too big");
  property p_lost; $past(reg_rd) && $past(reg_addr) == 8'h04
    |-> reg_rdata[31:16] == '0; endproperty
  a_lost: assert property (p_lost) else $error("lost too wide");
endmodule : eelg_monitor
bind eelg_top eelg_monitor #(.N_INPUTS(N_INPUTS), .LOG_DEPTH(LOG_DEPTH)) mon_u (
  .ref_clk(ref_clk), .arst_n(arst_n), .watch_in(watch_in),
  .pulse_out(pulse_out), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire

/* File: verif/eelg_hist_model.sv */
`timescale 1ns/1ps
`default_nettype none
module eelg_hist_model (
  input  wire logic        ref_clk,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_rdata,
  output logic             got,
  output logic [31:0]      word
);
  logic rd_d;
  // software copies each answer, valid only the cycle after its read
  always_ff @(posedge ref_clk) begin
    rd_d <= reg_rd;
    got  <= rd_d;
    word <= reg_rdata;
  end
endmodule : eelg_hist_model
`default_nettype wire

/* File: verif/test_eelg_top.sv */
`timescale 1ns/1ps
`default_nettype none
module test_eelg_top;
  logic        ref_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, got;
  logic [7:0]  watch_in = 0, pulse_out, reg_addr = 0, mask;
  logic [31:0] reg_wdata = 0, reg_rdata, word;
  logic [31:0] exp_q[$];
  int          bad_count = 0, n_compared = 0, seed = 77377;
  always #25 ref_clk = ~ref_clk;
  eelg_top #(.N_INPUTS(8), .LOG_DEPTH(8)) dut_u (.ref_clk(ref_clk),
    .arst_n(arst_n), .watch_in(watch_in), .pulse_out(pulse_out),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  eelg_hist_model hist_u (.ref_clk(ref_clk), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .got(got), .word(word));
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic check(string name, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", name, e, g);
    end
  endtask : check
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge ref_clk);
    reg_rd   <= 1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 0;
  endtask : rd
  task automatic pop(int i, logic [5:0] m);
    rd(8'h01, {1'b1, 15'h0, 8'(i), 2'b0, m});
  endtask : pop
  task automatic ev(logic [7:0] v, logic [7:0] e);
    @(posedge ref_clk);
    watch_in <= v;
    @(posedge ref_clk);
    #1 check("pulse_out", {24'h0, e}, {24'h0, pulse_out});
  endtask : ev
  always @(posedge ref_clk) if (got === 1'b1) begin
    check("reg_rdata", exp_q.pop_front(), word);
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    arst_n <= 1;
    rd(8'h03, 0);
    rd(8'h13, 3);
    rd(8'h40, 0);
    mask = 8'($random(seed)) | 8'h81;
    ev(mask, mask);
    repeat (12) @(posedge ref_clk);
    rd(8'h00, $countones(mask));
    for (int i = 0; i < 8; i++) if (mask[i]) pop(i, 6'(i));
    rd(8'h01, 0);
    ev(8'h00, 8'h00);
    ev(8'h01, 8'h01);
    wr(8'h03, 1);
    wr(8'h10, 32'h0000_003F);
    ev(8'h00, 8'h01);
    repeat (4) @(posedge ref_clk);
    pop(0, 0);
    pop(0, 6'h3F);
    // stress burst above the advisory rate, only to reach overflow
    for (int i = 0; i < 10; i++) begin
      ev(8'h02, 8'h02);
      ev(8'h00, 8'h00);
    end
    rd(8'h00, 8);
    rd(8'h04, 2);
    wr(8'h04, 0);
    rd(8'h04, 0);
    for (int i = 0; i < 8; i++) pop(1, 1);
    repeat (4) @(posedge ref_clk);
    give_verdict();
  end
  initial begin
    repeat (2000) @(posedge ref_clk);
    bad_count++;
    give_verdict();
  end
endmodule : test_eelg_top
`default_nettype wire
